// ### rtl/pll_ctrl_consts.svh
// Purpose: offsets, field positions, reset values and timing counts of the pll control slice
// Assumes: byte-wide register port, 40 MHz logic clock
// Notes:   definitions only
`ifndef PLL_CTRL_CONSTS_SVH
`define PLL_CTRL_CONSTS_SVH

// register offsets
`define PART_ID_HIGH_ADDR        8'h86
`define PART_ID_LOW_REV_ADDR     8'h87
`define RESET_CAL_CTRL_ADDR      8'h88
`define LOSS_MON_SEL_HIGH_ADDR   8'h8a
`define LOSS_MON_SEL_LOW_ADDR    8'h8b
`define LOCK_STATUS_ADDR         8'h82
`define RECAL_STATUS_ADDR        8'h8f

// calibration-sensitive configuration addresses
`define SENS_ADDR_0              8'h00
`define SENS_ADDR_1              8'h02
`define SENS_ADDR_2              8'h05
`define SENS_ADDR_3              8'h0a
`define SENS_ADDR_4              8'h0b
`define SENS_ADDR_5              8'h13
`define SENS_ADDR_6              8'h19
`define SENS_ADDR_7              8'h1f
`define SENS_ADDR_8              8'h28
`define SENS_ADDR_9              8'h2b
`define SENS_ADDR_10             8'h2e

// field positions
`define SOFT_RESET_BIT           7
`define CAL_START_BIT            6
`define LOSS_SEL_HIGH_BIT        0
`define LOSS_SEL_LOW_BIT         4

// reset and fixed values
`define LOSS_MON_SEL_HIGH_RESET  8'h0f
`define LOSS_MON_SEL_LOW_RESET   8'hff
`define LOCK_STATUS_RESET        8'h01
`define UNMAPPED_READ            8'h00

// loss monitor select encodings
`define LOSS_SEL_OFF             2'b00
`define LOSS_SEL_SLOW            2'b10
`define LOSS_SEL_NORMAL          2'b11

// timing
`define SYS_CLK_HZ               40000000
`define SOFT_RESET_HOLD_MS       10
`define SOFT_RESET_HOLD_CYCLES   ((`SOFT_RESET_HOLD_MS * `SYS_CLK_HZ) / 1000)

`endif

// ### rtl/pll_ctrl_pkg.sv
// Purpose: types shared by the pll control slice
// Assumes: nothing
// Notes:   offsets and counts live in pll_ctrl_consts.svh
package pll_ctrl_pkg;

  // calibration sequencer, gray along idle -> calibrating -> done
  typedef enum logic [1:0] {
    CAL_IDLE    = 2'b00,
    CAL_RUNNING = 2'b01,
    CAL_DONE    = 2'b11
  } cal_state_e;

  typedef logic [7:0] reg_byte_t;

endpackage

// ### rtl/pll_control_calibration_regs.sv
// Purpose: reset / calibration control, loss monitor select and identity registers of a pll clock multiplier
// Assumes: byte register port driven by the serial port engine on sys_clk; pll lock from the analog side
// Notes:   soft reset holds all state except the lock synchroniser and filter at defaults for a parameterised hold time
`timescale 1ns/10ps
`include "pll_ctrl_consts.svh"

module pll_control_calibration_regs #(
  parameter int         RST_HOLD_CYCLES = `SOFT_RESET_HOLD_CYCLES,
  parameter logic [11:0] PART_NUMBER    = 12'h5a3, // arbitrary value
  parameter logic [3:0]  REVISION       = 4'h1     // arbitrary value
) (
  // clock and external reset pin
  input  wire logic                   sys_clk,
  input  wire logic                   resetn,
  // register port
  input  wire logic [7:0]             reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [7:0]             reg_rdata,
  // analog pll side
  input  wire logic                   pll_locked,
  output logic                        cal_start_pulse,
  output logic                        logic_reset_n,
  output logic                        clk_out_enable,
  output logic                        lock_loss_alarm,
  output logic                        recal_needed,
  // loss monitor configuration
  output logic [1:0]                  loss_monitor_select,
  output logic                        loss_monitor_enable,
  output logic                        slow_loss_detector
);
  import pll_ctrl_pkg::*;

  // reset bytes as typed constants so that their bits can be selected
  localparam reg_byte_t SEL_HIGH_DEF = `LOSS_MON_SEL_HIGH_RESET;
  localparam reg_byte_t SEL_LOW_DEF  = `LOSS_MON_SEL_LOW_RESET;

  if (RST_HOLD_CYCLES < 1) begin : g_bad_hold
    $error("RST_HOLD_CYCLES must be at least one");
  end

  localparam int CW = $clog2(RST_HOLD_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////////////
  // state
  cal_state_e     cal_state_reg,   cal_state_next;
  logic [CW-1:0]  hold_cnt_reg,    hold_cnt_next;
  logic           sel_high_reg,    sel_high_next;
  logic           sel_low_reg,     sel_low_next;
  logic           recal_reg,       recal_next;
  logic           cal_pulse_reg,   cal_pulse_next;
  logic           clk_en_reg,      clk_en_next;
  logic           alarm_reg,       alarm_next;
  logic           lrst_n_reg,      lrst_n_next;
  logic [1:0]     sel_out_reg,     sel_out_next;
  logic           mon_en_reg,      mon_en_next;
  logic           slow_reg,        slow_next;
  reg_byte_t      rdata_reg,       rdata_next;
  logic [2:0]     lock_sync_reg;
  logic           locked_reg,      locked_next;

  logic in_reset;
  logic wr_ctrl;
  logic sens_write;

  ////////////////////////////////////////////////////////////////////////////
  // lock input from the analog domain: three flops, change once stages 2 and 3 agree
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lock_sync_reg <= 3'h0;
    end else begin
      lock_sync_reg <= {lock_sync_reg[1:0], pll_locked};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers
  assign in_reset = (hold_cnt_reg != '0);
  assign wr_ctrl  = reg_wr && !in_reset && (reg_addr == `RESET_CAL_CTRL_ADDR);

  // writes to configuration bytes that only a fresh calibration applies
  always_comb begin
    unique case (reg_addr)
      `SENS_ADDR_0, `SENS_ADDR_1, `SENS_ADDR_2, `SENS_ADDR_3, `SENS_ADDR_4, `SENS_ADDR_5,
      `SENS_ADDR_6, `SENS_ADDR_7, `SENS_ADDR_8, `SENS_ADDR_9, `SENS_ADDR_10: sens_write = reg_wr && !in_reset;
      default: sens_write = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic for the whole slice
  always_comb begin
    cal_state_next = cal_state_reg;
    hold_cnt_next  = hold_cnt_reg;
    sel_high_next  = sel_high_reg;
    sel_low_next   = sel_low_reg;
    recal_next     = recal_reg;
    cal_pulse_next = 1'b0;
    clk_en_next    = clk_en_reg;
    rdata_next     = rdata_reg;
    // filtered lock only moves when the last two sync stages agree
    locked_next    = (lock_sync_reg[2] == lock_sync_reg[1]) ? lock_sync_reg[2] : locked_reg;

    if (in_reset) begin
      // soft reset: everything except the filtered lock back to defaults, port deaf, clocks off
      hold_cnt_next  = hold_cnt_reg - CW'(1);
      cal_state_next = CAL_IDLE;
      sel_high_next  = SEL_HIGH_DEF[`LOSS_SEL_HIGH_BIT];
      sel_low_next   = SEL_LOW_DEF[`LOSS_SEL_LOW_BIT];
      recal_next     = 1'b0;
      clk_en_next    = 1'b0;
      rdata_next     = `UNMAPPED_READ;
    end else if (wr_ctrl && reg_wdata[`SOFT_RESET_BIT]) begin
      // drop status at the launching edge too, so no stale alarm or flag leaks into the hold
      hold_cnt_next  = CW'(RST_HOLD_CYCLES);
      clk_en_next    = 1'b0;
      cal_state_next = CAL_IDLE;
      recal_next     = 1'b0;
    end else begin
      // calibration sequencer; a zero in the start bit is simply ignored
      if (wr_ctrl && reg_wdata[`CAL_START_BIT]) begin
        cal_state_next = CAL_RUNNING;
        cal_pulse_next = 1'b1;
        recal_next     = 1'b0;
        clk_en_next    = 1'b0;
      end else begin
        unique case (cal_state_reg)
          CAL_IDLE: begin
            clk_en_next = 1'b0;
          end
          CAL_RUNNING: begin
            if (locked_reg) begin
              cal_state_next = CAL_DONE;
              clk_en_next    = 1'b1;
            end
          end
          CAL_DONE: begin
            if (sens_write) begin
              recal_next = 1'b1;
            end
          end
        endcase
      end

      // split monitor select writes
      if (reg_wr && reg_addr == `LOSS_MON_SEL_HIGH_ADDR) begin
        sel_high_next = reg_wdata[`LOSS_SEL_HIGH_BIT];
      end
      if (reg_wr && reg_addr == `LOSS_MON_SEL_LOW_ADDR) begin
        sel_low_next = reg_wdata[`LOSS_SEL_LOW_BIT];
      end

      // read data, reserved bits at their fixed values
      if (reg_rd) begin
        unique case (reg_addr)
          `PART_ID_HIGH_ADDR:      rdata_next = PART_NUMBER[11:4];
          `PART_ID_LOW_REV_ADDR:   rdata_next = {PART_NUMBER[3:0], REVISION};
          // start bit reads one while calibration runs, reset bit always reads zero
          `RESET_CAL_CTRL_ADDR:    rdata_next = {1'b0, cal_state_reg == CAL_RUNNING, 6'h00};
          `LOSS_MON_SEL_HIGH_ADDR: rdata_next = {SEL_HIGH_DEF[7:1], sel_high_reg};
          `LOSS_MON_SEL_LOW_ADDR:  rdata_next = {SEL_LOW_DEF[7:5], sel_low_reg, SEL_LOW_DEF[3:0]};
          `LOCK_STATUS_ADDR:       rdata_next = {7'h00, !locked_reg};
          `RECAL_STATUS_ADDR:      rdata_next = {7'h00, recal_reg};
          default:                 rdata_next = `UNMAPPED_READ;
        endcase
      end
    end

    // alarm stays high until the sequencer has seen lock after a calibration
    alarm_next   = !(cal_state_next == CAL_DONE && locked_next);
    lrst_n_next  = (hold_cnt_next == '0);

    // monitor decode; the reserved code 01 is treated as monitoring off
    sel_out_next = {sel_high_next, sel_low_next};
    mon_en_next  = (sel_out_next == `LOSS_SEL_SLOW) || (sel_out_next == `LOSS_SEL_NORMAL);
    slow_next    = (sel_out_next == `LOSS_SEL_SLOW);
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers; the pin reset forces the same defaults as the soft reset and also clears the filtered lock
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cal_state_reg <= CAL_IDLE;
      hold_cnt_reg  <= '0;
      sel_high_reg  <= SEL_HIGH_DEF[`LOSS_SEL_HIGH_BIT];
      sel_low_reg   <= SEL_LOW_DEF[`LOSS_SEL_LOW_BIT];
      recal_reg     <= 1'b0;
      cal_pulse_reg <= 1'b0;
      clk_en_reg    <= 1'b0;
      alarm_reg     <= 1'b1;
      lrst_n_reg    <= 1'b0;
      sel_out_reg   <= `LOSS_SEL_NORMAL;
      mon_en_reg    <= 1'b1;
      slow_reg      <= 1'b0;
      rdata_reg     <= `UNMAPPED_READ;
      locked_reg    <= 1'b0;
    end else begin
      cal_state_reg <= cal_state_next;
      hold_cnt_reg  <= hold_cnt_next;
      sel_high_reg  <= sel_high_next;
      sel_low_reg   <= sel_low_next;
      recal_reg     <= recal_next;
      cal_pulse_reg <= cal_pulse_next;
      clk_en_reg    <= clk_en_next;
      alarm_reg     <= alarm_next;
      lrst_n_reg    <= lrst_n_next;
      sel_out_reg   <= sel_out_next;
      mon_en_reg    <= mon_en_next;
      slow_reg      <= slow_next;
      rdata_reg     <= rdata_next;
      locked_reg    <= locked_next;
    end
  end

  // outputs straight from flops
  assign reg_rdata           = rdata_reg;
  assign cal_start_pulse     = cal_pulse_reg;
  assign logic_reset_n       = lrst_n_reg;
  assign clk_out_enable      = clk_en_reg;
  assign lock_loss_alarm     = alarm_reg;
  assign recal_needed        = recal_reg;
  assign loss_monitor_select = sel_out_reg;
  assign loss_monitor_enable = mon_en_reg;
  assign slow_loss_detector  = slow_reg;

endmodule

// ### sim/pll_ctrl_assertions.sv
// Purpose: concurrent checks on the ports of the pll control slice
// Assumes: one clock domain, resetn asynchronous active low
// Notes:   bound from the bench top file
`timescale 1ns/10ps
module pll_ctrl_assertions (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       resetn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // pll side and loss monitor
  input wire logic       pll_locked,
  input wire logic       cal_start_pulse,
  input wire logic       logic_reset_n,
  input wire logic       clk_out_enable,
  input wire logic       lock_loss_alarm,
  input wire logic       recal_needed,
  input wire logic [1:0] loss_monitor_select,
  input wire logic       loss_monitor_enable,
  input wire logic       slow_loss_detector
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////
  // writes to the control byte; port is dead while logic_reset_n low
  wire logic ctl_wr = reg_wr && (reg_addr == 8'h88);
  wire logic live   = logic_reset_n;
  a_pulse_one_cycle: assert property (cal_start_pulse |=> !cal_start_pulse)
    else $error("start pulse longer than one cycle");
  a_pulse_has_cause: assert property (cal_start_pulse |-> $past(ctl_wr && reg_wdata[7:6] == 2'b01))
    else $error("start pulse without a start write");
  a_start_launches: assert property (ctl_wr && reg_wdata[7:6] == 2'b01 && live && $past(live) |=> cal_start_pulse)
    else $error("start write did not launch");
  a_zero_no_start: assert property (ctl_wr && !reg_wdata[6] |=> !cal_start_pulse)
    else $error("zero in start bit launched");
  a_soft_reset_hits: assert property (ctl_wr && reg_wdata[7] && live && $past(live) |=> !live && !cal_start_pulse)
    else $error("soft reset write not honoured");
  a_reset_quiet: assert property (!live |-> !clk_out_enable && !cal_start_pulse && !recal_needed)
    else $error("outputs active during reset");
  a_select_decode: assert property ($stable(loss_monitor_select) |-> loss_monitor_enable == loss_monitor_select[1]
      && slow_loss_detector == (loss_monitor_select == 2'b10))
    else $error("monitor select decode wrong");
  a_alarm_fall_done: assert property ($fell(lock_loss_alarm) |-> clk_out_enable)
    else $error("alarm fell without completion");
  a_alarm_on_loss: assert property (!pll_locked [*6] |-> lock_loss_alarm)
    else $error("alarm low while unlocked");
  a_recal_set: assert property (reg_wr && live && clk_out_enable && reg_addr inside {8'h00, 8'h02, 8'h05, 8'h0a,
      8'h0b, 8'h13, 8'h19, 8'h1f, 8'h28, 8'h2b, 8'h2e} |=> recal_needed)
    else $error("sensitive write not flagged");
  a_start_clears: assert property (cal_start_pulse |-> !recal_needed && !clk_out_enable)
    else $error("start did not clear status");
  c_start: cover property (cal_start_pulse);
  c_done: cover property ($fell(lock_loss_alarm));
  c_recal: cover property ($rose(recal_needed));
  c_soft: cover property ($fell(logic_reset_n));
endmodule

// ### sim/pll_lock_model.sv
// Purpose: behavioural pll lock source for the control slice bench
// Assumes: a stable reference is always present at the selected input
// Notes:   lose_lock lets a scenario pull lock away on purpose
`timescale 1ns/10ps
module pll_lock_model #(
  parameter int LOCK_DELAY = 8
) (
  // clock
  input wire logic sys_clk,
  // start from the slice, fault from the bench
  input wire logic cal_start_pulse,
  input wire logic lose_lock,
  // internal reset of the device, pll falls out of lock while it is low
  input wire logic logic_reset_n,
  // lock to the slice
  output logic     pll_locked = 1'b0
);
  int   cnt      = 0;
  logic has_lock = 1'b0;
  // lock acquired some cycles after a start; kept if already held
  always @(posedge sys_clk) begin
    if (!logic_reset_n) begin
      cnt      <= 0;
      has_lock <= 1'b0;
    end else if (cal_start_pulse && !has_lock) begin
      cnt <= LOCK_DELAY;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      has_lock <= (cnt == 1);
    end
  end
  // analog level, changed just after the edge like any other input
  always @(posedge sys_clk) pll_locked <= #2 has_lock && !lose_lock;
endmodule

// ### sim/test_pll_control_calibration_regs.sv
// Purpose: self-checking bench of the pll control slice
// Assumes: soft reset hold shortened to 4 cycles
// Notes:   lock comes from pll_lock_model
`timescale 1ns/10ps
module test_pll_control_calibration_regs;
  import pll_ctrl_pkg::*;
  localparam int          HOLD = 4;
  localparam logic [11:0] PN   = 12'h5a3; // arbitrary value
  localparam logic [3:0]  REV  = 4'h1;    // arbitrary value
  logic       sys_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, lose_lock = 1'b0;
  reg_byte_t  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [1:0] loss_monitor_select;
  logic       cal_start_pulse, logic_reset_n, clk_out_enable, lock_loss_alarm, recal_needed;
  logic       loss_monitor_enable, slow_loss_detector, pll_locked;
  int         fails = 0, total_checks = 0;
  reg_byte_t  da [5] = '{8'h8a, 8'h8b, 8'h88, 8'h82, 8'h8f};
  reg_byte_t  de [5] = '{8'h0f, 8'hff, 8'h00, 8'h01, 8'h00};
  reg_byte_t  sens [11] = '{8'h00, 8'h02, 8'h05, 8'h0a, 8'h0b, 8'h13, 8'h19, 8'h1f, 8'h28, 8'h2b, 8'h2e};
  initial forever #12.5 sys_clk = ~sys_clk;
  pll_control_calibration_regs #(.RST_HOLD_CYCLES(HOLD), .PART_NUMBER(PN), .REVISION(REV)) dut (
    .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pll_locked(pll_locked), .cal_start_pulse(cal_start_pulse),
    .logic_reset_n(logic_reset_n), .clk_out_enable(clk_out_enable), .lock_loss_alarm(lock_loss_alarm),
    .recal_needed(recal_needed), .loss_monitor_select(loss_monitor_select),
    .loss_monitor_enable(loss_monitor_enable), .slow_loss_detector(slow_loss_detector));
  pll_lock_model pll_u (.sys_clk(sys_clk), .cal_start_pulse(cal_start_pulse), .lose_lock(lose_lock),
    .logic_reset_n(logic_reset_n), .pll_locked(pll_locked));
  ////////////////////////////////////////////////////////////////
  // compare, verdict and port tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // one access per task, released only after the taking edge
  task automatic wr(input reg_byte_t a, input reg_byte_t d);
    @(posedge sys_clk) #2;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge sys_clk) #2;
    reg_wr = 1'b0;
  endtask
  task automatic rd(input reg_byte_t a, input reg_byte_t e);
    @(posedge sys_clk) #2;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge sys_clk) #2;
    reg_rd = 1'b0;
    chk(reg_rdata, e);
  endtask
  // bounded wait for completion; running out ends the run
  task automatic wait_done;
    for (int i = 0; i < 60 && !(clk_out_enable === 1'b1 && lock_loss_alarm === 1'b0); i++)
      @(posedge sys_clk) #2;
    if (clk_out_enable !== 1'b1 || lock_loss_alarm !== 1'b0) begin
      fails++;
      stop_test();
    end
  endtask
  task automatic do_cal;
    wr(8'h88, 8'h40);
    chk({7'h00, cal_start_pulse}, 8'h01);
    wait_done();
  endtask
  task automatic defaults;
    chk({1'b0, recal_needed, loss_monitor_select, loss_monitor_enable, slow_loss_detector, lock_loss_alarm,
      clk_out_enable}, 8'h3a);
    for (int k = 0; k < 5; k++) rd(da[k], de[k]);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge sys_clk);
    #2 resetn = 1'b1;
    defaults();
    wr(8'h86, 8'h00);
    wr(8'h87, 8'h00);
    rd(8'h86, PN[11:4]);
    rd(8'h87, {PN[3:0], REV});
    rd(8'h90, 8'h00);
    // every select code, reserved bits written as zero
    for (int i = 0; i < 4; i++) begin
      wr(8'h8a, {7'h00, i[1]});
      wr(8'h8b, {3'h0, i[0], 4'h0});
      rd(8'h8a, {7'h07, i[1]});
      rd(8'h8b, {3'h7, i[0], 4'hf});
      chk({6'h00, loss_monitor_select}, 8'(i));
      chk({7'h00, loss_monitor_enable}, {7'h00, i[1]});
      chk({7'h00, slow_loss_detector}, {7'h00, i == 2});
    end
    // configure first, then the first calibration from unlocked
    wr(8'h13, 8'h11);
    chk({7'h00, recal_needed}, 8'h00);
    wr(8'h88, 8'h40);
    chk({7'h00, cal_start_pulse}, 8'h01);
    rd(8'h88, 8'h40);
    wait_done();
    rd(8'h82, 8'h00);
    rd(8'h88, 8'h00);
    wr(8'h88, 8'h00);
    chk({7'h00, cal_start_pulse}, 8'h00);
    for (int k = 0; k < 11; k++) begin
      wr(8'h14, 8'h5a);
      chk({7'h00, recal_needed}, 8'h00);
      wr(sens[k], 8'h5a);
      rd(8'h8f, 8'h01);
      do_cal();
      chk({7'h00, recal_needed}, 8'h00);
    end
    // lock pulled away after completion
    lose_lock = 1'b1;
    repeat (8) @(posedge sys_clk);
    #2 chk({6'h00, lock_loss_alarm, clk_out_enable}, 8'h03);
    rd(8'h82, 8'h01);
    lose_lock = 1'b0;
    wait_done();
    // soft reset together with a start: reset wins
    wr(8'h8a, 8'h00);
    wr(8'h88, 8'hc0);
    chk({6'h00, logic_reset_n, cal_start_pulse}, 8'h00);
    chk({7'h00, clk_out_enable}, 8'h00);
    repeat (HOLD + 2) @(posedge sys_clk);
    #2 chk({7'h00, logic_reset_n}, 8'h01);
    defaults();
    // pin reset in mid-run
    wr(8'h8b, 8'h00);
    resetn = 1'b0;
    repeat (2) @(posedge sys_clk);
    #2 resetn = 1'b1;
    defaults();
    stop_test();
  end
endmodule
bind pll_control_calibration_regs pll_ctrl_assertions chk_u (
  .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pll_locked(pll_locked), .cal_start_pulse(cal_start_pulse),
  .logic_reset_n(logic_reset_n), .clk_out_enable(clk_out_enable), .lock_loss_alarm(lock_loss_alarm),
  .recal_needed(recal_needed), .loss_monitor_select(loss_monitor_select),
  .loss_monitor_enable(loss_monitor_enable), .slow_loss_detector(slow_loss_detector));
